// ===== core/docm_pkg.sv
// Shared constants, register map, field layout and state types for the output channel.
// Assumes a single 25 MHz clock and a 32-bit AHB-Lite register bus.
package docm_pkg;

    // Clock and time base.
    localparam int CLK_PERIOD_NS = 40;
    localparam int STEP_NS       = 100000;
    localparam int STEP_CYCLES   = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths.
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;

    // Register byte offsets.
    localparam logic [7:0] DOCM_CTRL_OFS   = 8'h00;
    localparam logic [7:0] DOCM_LOW_OFS    = 8'h04;
    localparam logic [7:0] DOCM_HIGH_OFS   = 8'h08;
    localparam logic [7:0] DOCM_TOTAL_OFS  = 8'h0c;
    localparam logic [7:0] DOCM_DELAY_OFS  = 8'h10;
    localparam logic [7:0] DOCM_CMD_OFS    = 8'h14;
    localparam logic [7:0] DOCM_STATUS_OFS = 8'h18;

    // Field positions.
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_MODE_MSB   = 1;
    localparam int CTRL_LEVEL_BIT  = 2;
    localparam int CTRL_FIXED_BIT  = 3;
    localparam int CMD_START_BIT   = 0;
    localparam int CMD_STOP_BIT    = 1;
    localparam int STAT_LEVEL_BIT  = 0;
    localparam int STAT_BUSY_BIT   = 1;
    localparam int STAT_COUNT_LSB  = 16;
    localparam int STAT_COUNT_MSB  = 31;

    // Reset values and bus codes.
    localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
    localparam logic [1:0]        HTRANS_NSQ = 2'h2;
    localparam logic [1:0]        HTRANS_SEQ = 2'h3;
    localparam logic              HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        MODE_DIRECT   = 2'h0,
        MODE_PULSE    = 2'h1,
        MODE_RISE_DLY = 2'h2,
        MODE_FALL_DLY = 2'h3
    } docm_mode_t;

    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_LOW  = 3'b010,
        PS_HIGH = 3'b100
    } docm_pstate_t;

    typedef enum logic [1:0] {
        DS_STABLE = 2'b01,
        DS_WAIT   = 2'b10
    } docm_dstate_t;

    // A zero width would make a phase vanish; it is treated as one step.
    function automatic logic [CNT_W-1:0] docm_width(input logic [CNT_W-1:0] w);
        docm_width = (w == CNT_RST) ? 16'h0001 : w;
    endfunction

endpackage

// ===== core/docm_tick.sv
// Restartable prescaler that pulses once per 0.1 ms step.
// Assumes CE freezes it and that restart aligns the next step to a full period.
`timescale 1ns/1ps
`default_nettype none
module docm_tick #(
    parameter int CYCLES = docm_pkg::STEP_CYCLES
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Control and step output.
    input  wire logic restart,
    output logic      tick
);
    import docm_pkg::*;

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // A restart pulls the phase back so a new step lasts exactly one full period.
    always_comb begin
        cnt_d = cnt_q;
        tick  = 1'b0;
        if (restart) begin
            cnt_d = ZERO;
        end else if (cnt_q == LAST) begin
            cnt_d = ZERO;
            tick  = ce;
        end else begin
            cnt_d = CW'(cnt_q + 1'b1);
        end
    end

    // Counter register, frozen while the clock enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= ZERO;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

endmodule
`default_nettype wire

// ===== core/docm_pulse.sv
// Pulse engine: low phase then high phase, continuous or a fixed number of pulses.
// Assumes step ticks from a prescaler that it restarts on start.
`timescale 1ns/1ps
`default_nettype none
module docm_pulse (
    // Clock and reset.
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // Time base.
    input  wire logic                       tick,
    output logic                            restart,
    // Commands and settings.
    input  wire logic                       start,
    input  wire logic                       stop,
    input  wire logic                       fixed,
    input  wire logic [docm_pkg::CNT_W-1:0] low_w,
    input  wire logic [docm_pkg::CNT_W-1:0] high_w,
    input  wire logic [docm_pkg::CNT_W-1:0] total,
    // State.
    output logic                            level,
    output logic                            busy,
    output logic [docm_pkg::CNT_W-1:0]      count
);
    import docm_pkg::*;

    docm_pstate_t     st_q,  st_d;
    logic [CNT_W-1:0] ph_q,  ph_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             lvl_q, lvl_d;
    logic [CNT_W-1:0] ph_next;
    logic [CNT_W-1:0] cnt_next;

    assign ph_next  = CNT_W'(ph_q + 1'b1);
    assign cnt_next = CNT_W'(cnt_q + 1'b1);
    assign level    = lvl_q;
    assign busy     = (st_q != PS_IDLE);
    assign count    = cnt_q;

    // Phase sequencing; stop wins over start and over any phase change.
    always_comb begin
        st_d    = st_q;
        ph_d    = ph_q;
        cnt_d   = cnt_q;
        lvl_d   = lvl_q;
        restart = 1'b0;
        case (st_q)
            PS_IDLE: begin
                lvl_d = 1'b0;
                if (start && !stop && !(fixed && total == CNT_RST)) begin
                    st_d    = PS_LOW;
                    ph_d    = CNT_RST;
                    cnt_d   = CNT_RST;
                    restart = 1'b1;
                end
            end
            PS_LOW: begin
                if (stop) begin
                    st_d  = PS_IDLE;
                    lvl_d = 1'b0;
                end else if (tick) begin
                    if (ph_next >= docm_width(low_w)) begin
                        st_d  = PS_HIGH;
                        ph_d  = CNT_RST;
                        lvl_d = 1'b1;
                    end else begin
                        ph_d = ph_next;
                    end
                end
            end
            PS_HIGH: begin
                if (stop) begin
                    st_d  = PS_IDLE;
                    lvl_d = 1'b0;
                end else if (tick) begin
                    if (ph_next >= docm_width(high_w)) begin
                        ph_d  = CNT_RST;
                        lvl_d = 1'b0;
                        cnt_d = cnt_next;
                        // A burst ends by itself at the low level after its last pulse.
                        if (fixed && cnt_next >= total) begin
                            st_d = PS_IDLE;
                        end else begin
                            st_d = PS_LOW;
                        end
                    end else begin
                        ph_d = ph_next;
                    end
                end
            end
            default: begin
                st_d  = PS_IDLE;
                lvl_d = 1'b0;
            end
        endcase
    end

    // Engine registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= PS_IDLE;
            ph_q  <= CNT_RST;
            cnt_q <= CNT_RST;
            lvl_q <= 1'b0;
        end else if (ce) begin
            st_q  <= st_d;
            ph_q  <= ph_d;
            cnt_q <= cnt_d;
            lvl_q <= lvl_d;
        end
    end

endmodule
`default_nettype wire

// ===== core/docm_top.sv
// Digital output channel with direct, pulse, rising-delay and falling-delay modes.
// Assumes one 25 MHz clock, an AHB-Lite master with single word transfers, and CE high while the bus is used.
// Only HADDR[7:0] is decoded; the map repeats above it.
// CE low freezes every register of the block.
// Widths and delays are 16-bit numbers of 0.1 ms steps; the total is a 16-bit number of pulses.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module docm_top #(
    parameter int STEP_CYCLES = docm_pkg::STEP_CYCLES
) (
    // Clock, reset and enable.
    input  wire logic                        CLK,
    input  wire logic                        RST_N,
    input  wire logic                        CE,

    // AHB-Lite slave.
    input  wire logic                        HSEL,
    input  wire logic [31:0]                 HADDR,
    input  wire logic [1:0]                  HTRANS,
    input  wire logic                        HWRITE,
    input  wire logic [2:0]                  HSIZE,
    input  wire logic [docm_pkg::DATA_W-1:0] HWDATA,
    input  wire logic                        HREADY,
    output logic      [docm_pkg::DATA_W-1:0] HRDATA,
    output logic                             HREADYOUT,
    output logic                             HRESP,

    // Channel pin.
    output logic                             DO_OUT
);
    import docm_pkg::*;

    // Register state.
    docm_mode_t       mode_q,   mode_d;
    logic             cmd_q,    cmd_d;
    logic             fixed_q,  fixed_d;
    logic [CNT_W-1:0] low_q,    low_d;
    logic [CNT_W-1:0] high_q,   high_d;
    logic [CNT_W-1:0] total_q,  total_d;
    logic [CNT_W-1:0] dly_q,    dly_d;

    // One-cycle command strobes.
    logic             start_q,  start_d;
    logic             stop_q,   stop_d;

    // Bus state.
    logic             wr_q,     wr_d;
    logic [7:0]       wadr_q,   wadr_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;

    // Bus answer registers.
    logic             rdy_q;
    logic             resp_q;

    // Delay and pin state.
    docm_dstate_t     ds_q,     ds_d;
    logic [CNT_W-1:0] dcnt_q,   dcnt_d;
    logic             out_q,    out_d;

    // Internal nets of the pulse engine.
    logic             p_tick;
    logic             p_restart;
    logic             p_level;
    logic             p_busy;
    logic [CNT_W-1:0] p_count;

    // Delay prescaler.
    logic             d_tick;
    logic             d_restart;

    // Bus decode and delay step count.
    logic             addr_ok;
    logic [7:0]       radr;
    logic [CNT_W-1:0] dcnt_next;

    // Transfer qualifier, read address and delay step arithmetic.
    assign addr_ok   = HSEL && HREADY && (HTRANS == HTRANS_NSQ || HTRANS == HTRANS_SEQ);
    assign radr      = HADDR[7:0];
    assign dcnt_next = CNT_W'(dcnt_q + 1'b1);

    // Every output leaves a register.
    assign HRDATA    = rdata_q;
    assign HREADYOUT = rdy_q;
    assign HRESP     = resp_q;
    assign DO_OUT    = out_q;

    // Time base for the pulse engine, restarted on start so the first phase is full length.
    // A prescaler of its own keeps delays from bending the train.
    docm_tick #(
        .CYCLES  (STEP_CYCLES)
    ) u_ptick (
        .clk     (CLK),
        .rst_n   (RST_N),
        .ce      (CE),
        .restart (p_restart),
        .tick    (p_tick)
    );

    // Time base for edge delays, restarted whenever a delayed edge is first seen.
    // A cancelled edge leaves it running, which is harmless.
    docm_tick #(
        .CYCLES  (STEP_CYCLES)
    ) u_dtick (
        .clk     (CLK),
        .rst_n   (RST_N),
        .ce      (CE),
        .restart (d_restart),
        .tick    (d_tick)
    );

    // Start is only honoured in pulse mode; leaving pulse mode forces a stop.
    // A cut pulse always leaves the engine at the low level.
    docm_pulse u_pulse (
        .clk     (CLK),
        .rst_n   (RST_N),
        .ce      (CE),

        .tick    (p_tick),
        .restart (p_restart),

        .start   (start_q && mode_q == MODE_PULSE),
        .stop    (stop_q || mode_q != MODE_PULSE),
        .fixed   (fixed_q),
        .low_w   (low_q),
        .high_w  (high_q),
        .total   (total_q),
        .level   (p_level),
        .busy    (p_busy),
        .count   (p_count)
    );

    // Bus next state: writes land in the data phase, reads are prepared in the address phase.
    // Command bits live one cycle, so no later write replays them.
    always_comb begin
        mode_d  = mode_q;
        cmd_d   = cmd_q;
        fixed_d = fixed_q;
        low_d   = low_q;
        high_d  = high_q;
        total_d = total_q;
        dly_d   = dly_q;

        start_d = 1'b0;
        stop_d  = 1'b0;

        wr_d    = addr_ok && HWRITE;
        wadr_d  = radr;
        rdata_d = DATA_ZERO;

        // Data phase: apply the write captured one edge earlier.
        if (wr_q) begin
            if (wadr_q == DOCM_CTRL_OFS) begin
                mode_d  = docm_mode_t'(HWDATA[CTRL_MODE_MSB:CTRL_MODE_LSB]);
                cmd_d   = HWDATA[CTRL_LEVEL_BIT];
                fixed_d = HWDATA[CTRL_FIXED_BIT];
            end else if (wadr_q == DOCM_LOW_OFS) begin
                low_d = HWDATA[CNT_W-1:0];
            end else if (wadr_q == DOCM_HIGH_OFS) begin
                high_d = HWDATA[CNT_W-1:0];
            end else if (wadr_q == DOCM_TOTAL_OFS) begin
                total_d = HWDATA[CNT_W-1:0];
            end else if (wadr_q == DOCM_DELAY_OFS) begin
                dly_d = HWDATA[CNT_W-1:0];
            end else if (wadr_q == DOCM_CMD_OFS) begin
                // Strobes: a zero bit does nothing.
                start_d = HWDATA[CMD_START_BIT];
                stop_d  = HWDATA[CMD_STOP_BIT];
            end
        end

        // Address phase: a read sees a write landing in this cycle.
        if (addr_ok && !HWRITE) begin
            if (radr == DOCM_CTRL_OFS) begin
                rdata_d[CTRL_MODE_MSB:CTRL_MODE_LSB] = mode_d;
                rdata_d[CTRL_LEVEL_BIT]              = cmd_d;
                rdata_d[CTRL_FIXED_BIT]              = fixed_d;
            end else if (radr == DOCM_LOW_OFS) begin
                rdata_d[CNT_W-1:0] = low_d;
            end else if (radr == DOCM_HIGH_OFS) begin
                rdata_d[CNT_W-1:0] = high_d;
            end else if (radr == DOCM_TOTAL_OFS) begin
                rdata_d[CNT_W-1:0] = total_d;
            end else if (radr == DOCM_DELAY_OFS) begin
                rdata_d[CNT_W-1:0] = dly_d;
            end else if (radr == DOCM_STATUS_OFS) begin
                // Busy drops by itself once a burst is over.
                rdata_d[STAT_LEVEL_BIT]                = out_q;
                rdata_d[STAT_BUSY_BIT]                 = p_busy;
                rdata_d[STAT_COUNT_MSB:STAT_COUNT_LSB] = p_count;
            end
        end
    end

    // Bus and setting registers.
    // A bus write while CE is low is lost.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q  <= MODE_DIRECT;
            cmd_q   <= 1'b0;
            fixed_q <= 1'b0;
            low_q   <= CNT_RST;
            high_q  <= CNT_RST;
            total_q <= CNT_RST;
            dly_q   <= CNT_RST;
            start_q <= 1'b0;
            stop_q  <= 1'b0;
            wr_q    <= 1'b0;
            wadr_q  <= DOCM_CTRL_OFS;
            rdata_q <= DATA_ZERO;
        end else if (CE) begin
            mode_q  <= mode_d;
            cmd_q   <= cmd_d;
            fixed_q <= fixed_d;
            low_q   <= low_d;
            high_q  <= high_d;
            total_q <= total_d;
            dly_q   <= dly_d;
            start_q <= start_d;
            stop_q  <= stop_d;
            wr_q    <= wr_d;
            wadr_q  <= wadr_d;
            rdata_q <= rdata_d;
        end
    end

    // Bus answer flops: this slave never stalls and always answers OKAY.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdy_q  <= 1'b1;
            resp_q <= HRESP_OKAY;
        end else if (CE) begin
            rdy_q  <= 1'b1;
            resp_q <= HRESP_OKAY;
        end
    end

    // Pin next state. The delayed edge direction waits its time; the opposite edge passes at once,
    // which also cancels a pending delayed edge so a short command glitch never reaches the pin.
    // A new delay written while an edge is pending applies to the steps still to come.
    always_comb begin
        ds_d      = ds_q;
        dcnt_d    = dcnt_q;
        out_d     = out_q;
        d_restart = 1'b0;

        case (mode_q)
            MODE_PULSE: begin
                // The engine level is re-timed by the pin flop.
                ds_d  = DS_STABLE;
                out_d = p_level;
            end

            MODE_RISE_DLY, MODE_FALL_DLY: begin
                // Nothing is pending once the pin agrees.
                if (cmd_q == out_q) begin
                    ds_d = DS_STABLE;
                end else if ((mode_q == MODE_RISE_DLY) != cmd_q) begin
                    ds_d  = DS_STABLE;
                    out_d = cmd_q;
                end else if (dly_q == CNT_RST) begin
                    out_d = cmd_q;
                end else if (ds_q == DS_STABLE) begin
                    ds_d      = DS_WAIT;
                    dcnt_d    = CNT_RST;
                    d_restart = 1'b1;
                end else if (d_tick) begin
                    dcnt_d = dcnt_next;
                    if (dcnt_next >= dly_q) begin
                        ds_d  = DS_STABLE;
                        out_d = cmd_q;
                    end
                end
            end

            default: begin
                // Direct: the command reaches the pin at the next edge.
                ds_d  = DS_STABLE;
                out_d = cmd_q;
            end
        endcase
    end

    // Pin and delay registers.
    // No decode logic sits between out_q and the pin.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ds_q   <= DS_STABLE;
            dcnt_q <= CNT_RST;
            out_q  <= 1'b0;
        end else if (CE) begin
            ds_q   <= ds_d;
            dcnt_q <= dcnt_d;
            out_q  <= out_d;
        end
    end

endmodule
`default_nettype wire

// ===== sim/docm_chk.sv
// Port-level assertions for the digital output channel top module.
// Assumes it is bound to docm_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module docm_chk #(
    parameter int STEP_CYCLES = docm_pkg::STEP_CYCLES
) (
    // Clock, reset and enable.
    input wire logic                        CLK,
    input wire logic                        RST_N,
    input wire logic                        CE,
    // Bus and pin.
    input wire logic                        HSEL,
    input wire logic [31:0]                 HADDR,
    input wire logic [1:0]                  HTRANS,
    input wire logic                        HWRITE,
    input wire logic [2:0]                  HSIZE,
    input wire logic [docm_pkg::DATA_W-1:0] HWDATA,
    input wire logic                        HREADY,
    input wire logic [docm_pkg::DATA_W-1:0] HRDATA,
    input wire logic                        HREADYOUT,
    input wire logic                        HRESP,
    input wire logic                        DO_OUT
);
    import docm_pkg::*;
    logic        aw_q;
    logic [7:0]  ad_q;
    logic [1:0]  mode_q;
    logic        lvl_q;
    logic [15:0] dly_q;
    logic        rd_go;
    logic        wr_ctrl;
    logic        wr_cmd;

    // Shadow of the settings, so that mode-dependent checks know the old and new values.
    assign rd_go   = HSEL && HREADY && HTRANS[1] && CE && !HWRITE;
    assign wr_ctrl = aw_q && CE && (ad_q == DOCM_CTRL_OFS);
    assign wr_cmd  = aw_q && CE && (ad_q == DOCM_CMD_OFS);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_q   <= 1'b0;
            ad_q   <= 8'h00;
            mode_q <= 2'h0;
            lvl_q  <= 1'b0;
            dly_q  <= 16'h0000;
        end else if (CE) begin
            aw_q <= HSEL && HREADY && HTRANS[1] && HWRITE;
            ad_q <= HADDR[7:0];
            mode_q <= wr_ctrl ? HWDATA[1:0] : mode_q;
            lvl_q  <= wr_ctrl ? HWDATA[CTRL_LEVEL_BIT] : lvl_q;
            dly_q  <= (aw_q && ad_q == DOCM_DELAY_OFS) ? HWDATA[15:0] : dly_q;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // Bus answers are fixed, so a master never stalls or sees an error.
    property p_ready; HREADYOUT == 1'b1; endproperty
    a_ready: assert property (p_ready) else $error("hreadyout not high");
    property p_okay; HRESP == HRESP_OKAY; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rst; disable iff (1'b0) !RST_N |-> !DO_OUT; endproperty
    a_rst: assert property (p_rst) else $error("pin high in reset");
    property p_unmap; rd_go && (HADDR[7:0] > 8'h18 || HADDR[7:0] == DOCM_CMD_OFS) |=> HRDATA == DATA_ZERO; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped or command read not zero");
    property p_stat; rd_go && HADDR[7:0] == DOCM_STATUS_OFS |=> HRDATA[STAT_LEVEL_BIT] == $past(DO_OUT); endproperty
    a_stat: assert property (p_stat) else $error("status level differs from pin");
    property p_direct; wr_ctrl && HWDATA[1:0] == 2'h0 ##1 CE ##1 CE |-> DO_OUT == $past(lvl_q); endproperty
    a_direct: assert property (p_direct) else $error("direct level not on pin");
    // The delayed edge must not slip through early; three cycles is the shortest legal delay.
    property p_rise;
        wr_ctrl && mode_q == 2'h2 && !lvl_q && dly_q != 16'h0 && HWDATA[2:0] == 3'h6 && !DO_OUT |=> !DO_OUT[*3];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge not delayed");
    property p_fall;
        wr_ctrl && mode_q == 2'h3 && lvl_q && dly_q != 16'h0 && HWDATA[2:0] == 3'h3 && DO_OUT |=> DO_OUT[*3];
    endproperty
    a_fall: assert property (p_fall) else $error("falling edge not delayed");
    property p_stop; wr_cmd && HWDATA[CMD_STOP_BIT] && mode_q == 2'h1 |-> ##[1:3] !DO_OUT; endproperty
    a_stop: assert property (p_stop) else $error("stop did not drop pin");

    c_pulse: cover property (wr_ctrl && HWDATA[1:0] == 2'h1);
    c_stop: cover property (wr_cmd && HWDATA[CMD_STOP_BIT] && mode_q == 2'h1);
    c_rise: cover property ($rose(DO_OUT) && mode_q == 2'h2);
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the output channel: registers, direct, pulse and delay modes.
// Assumes a single AHB-Lite slave and a step shortened to four clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import docm_pkg::*;
    localparam int SC = 4;
    logic        clk = 1'b0;
    logic        rst_n;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        do_out;
    logic [31:0] rd;
    int          n;
    int          miscompares = 0;
    int          cmp_count = 0;

    docm_top #(.STEP_CYCLES(SC)) u_docm_top (
        .CLK(clk), .RST_N(rst_n), .CE(1'b1), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .DO_OUT(do_out));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One single transfer; each phase is held until hready is seen high at an edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        htrans <= HTRANS_NSQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // Counts settled half-cycle samples until the pin shows v; gives up after 300.
    task automatic wait_lvl(input logic v);
        n = 0;
        while (do_out !== v && n < 300) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_regs;
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'(i * 4), DATA_ZERO, rd);
            chk(rd, DATA_ZERO);
        end
        bus(1'b1, DOCM_LOW_OFS, 32'hffff_1234, rd);
        bus(1'b0, DOCM_LOW_OFS, DATA_ZERO, rd);
        chk(rd, 32'h0000_1234);
        bus(1'b1, 8'h20, 32'h5a5a_5a5a, rd);
        bus(1'b0, 8'h20, DATA_ZERO, rd);
        chk(rd, DATA_ZERO);
    endtask

    task automatic t_direct;
        for (int v = 1; v >= 0; v--) begin
            bus(1'b1, DOCM_CTRL_OFS, 32'(v * 4), rd);
            repeat (2) @(negedge clk);
            chk({31'h0, do_out}, 32'(v));
            bus(1'b0, DOCM_STATUS_OFS, DATA_ZERO, rd);
            chk(rd, 32'(v));
        end
    endtask

    // A burst of three pulses, then the channel must fall idle on its own.
    task automatic t_fixed;
        bus(1'b1, DOCM_LOW_OFS, 32'h2, rd);
        bus(1'b1, DOCM_HIGH_OFS, 32'h3, rd);
        bus(1'b1, DOCM_TOTAL_OFS, 32'h3, rd);
        bus(1'b1, DOCM_CTRL_OFS, 32'h9, rd);
        bus(1'b1, DOCM_CMD_OFS, 32'h1, rd);
        for (int i = 0; i < 3; i++) begin
            wait_lvl(1'b1);
            if (i > 0) chk(32'(n), 32'(2 * SC));
            wait_lvl(1'b0);
            chk(32'(n), 32'(3 * SC));
        end
        wait_lvl(1'b1);
        chk(32'(n), 32'd300);
        bus(1'b0, DOCM_STATUS_OFS, DATA_ZERO, rd);
        chk(rd, 32'h0003_0000);
    endtask

    // Continuous train outlives the programmed total and ends only on stop.
    task automatic t_cont;
        bus(1'b1, DOCM_LOW_OFS, 32'h1, rd);
        bus(1'b1, DOCM_HIGH_OFS, 32'h2, rd);
        bus(1'b1, DOCM_CTRL_OFS, 32'h1, rd);
        bus(1'b1, DOCM_CMD_OFS, 32'h1, rd);
        for (int i = 0; i < 4; i++) begin
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            chk(32'(n), 32'(2 * SC));
        end
        wait_lvl(1'b1);
        bus(1'b1, DOCM_CMD_OFS, 32'h2, rd);
        repeat (3) @(negedge clk);
        chk({31'h0, do_out}, DATA_ZERO);
        bus(1'b0, DOCM_STATUS_OFS, DATA_ZERO, rd);
        chk({30'h0, rd[1:0]}, DATA_ZERO);
    endtask

    // Delayed edge takes at least the programmed time; the other edge passes at once.
    task automatic t_delay;
        bus(1'b1, DOCM_DELAY_OFS, 32'h2, rd);
        bus(1'b1, DOCM_CTRL_OFS, 32'h2, rd);
        bus(1'b1, DOCM_CTRL_OFS, 32'h6, rd);
        wait_lvl(1'b1);
        chk(32'(n >= 2 * SC && n <= 2 * SC + 5), 32'h1);
        bus(1'b1, DOCM_CTRL_OFS, 32'h2, rd);
        wait_lvl(1'b0);
        chk(32'(n <= 3), 32'h1);
        bus(1'b1, DOCM_CTRL_OFS, 32'h7, rd);
        wait_lvl(1'b1);
        chk(32'(n <= 3), 32'h1);
        bus(1'b1, DOCM_CTRL_OFS, 32'h3, rd);
        wait_lvl(1'b0);
        chk(32'(n >= 2 * SC && n <= 2 * SC + 5), 32'h1);
    endtask

    task automatic wrap_up;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence after three cycles of reset.
    initial begin
        rst_n <= 1'b0; // Scheduled so the reset edge is seen at time zero.
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_direct;
        t_fixed;
        t_cont;
        t_delay;
        wrap_up;
    end

    // The whole run needs well under a thousand cycles; ten thousand means a hang.
    initial begin
        #400000;
        miscompares++;
        wrap_up;
    end
endmodule

bind docm_top docm_chk #(.STEP_CYCLES(STEP_CYCLES)) u_docm_chk (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .DO_OUT(DO_OUT));
`default_nettype wire
